// file: rtl/pdc_core.sv
// Purpose: Predistortion stage with its slave serial configuration port.
// Assumes: Samples arrive one per clock on two lanes, synchronous to clock; the serial
//          port runs on spi_sclk and is reset by a high select.
// Notes:   Read data is fetched across domains on a request level; the serial clock limit
//          leaves well over two core cycles between request and first data bit.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Alternate samples scaled by gain one, added.
// - Every other step scaled, phase-aligned, added.
// - Spur path: prefilter, Hilbert, sum, square, modulate.
// - Modulation starts at programmed polarity, then alternates.
// - Hilbert branch uses gain ten, zero branch nine.
// - Active latency exceeds bypass by delay three.
// - All gains reset to zero.
// - Fifteen-bit input, LSB dropped to fourteen.
// - Delays reset to 1, 12, 6.
// - Spur d3, interleave d3+6, PA/main d3+7.
// - Delay three saturates at nine.
// - Delays one, two 0..15; three 0..9.
// - Gain ranges and resolutions per coefficient group.
// - Config bit sets spur correction sign.
// - Prefilter skip bit bypasses spur prefilter.
// - Off bits blank lanes A/C and B/D.
// - Parity bit chooses which sample is held.
// - Bypass output equals all gains zero with delay three at zero.
// - Frame: rw, 12-bit address, idle, 16 data.
// - Output enabled only for read data bits.
module pdc_core (
  input  wire logic                  clock,      // DSP clock
  input  wire logic                  reset,      // synchronous, active high
  input  wire pdc_pkg::pdc_samples_t samples_in, // two input lanes, one sample each per clock
  output logic [13:0]                sample_out, // corrected output sample
  input  wire logic                  spi_sclk,   // serial clock from the master
  input  wire logic                  spi_ss_n,   // serial select, active low
  input  wire logic                  spi_sdi,    // serial data in
  output logic                       spi_sdo,    // serial data out
  output logic                       spi_sdo_oe  // serial data out enable, high drives
);

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic signed [31:0] mulsh(input logic signed [15:0] a,
                                               input logic signed [11:0] g,
                                               input int sh);
    logic signed [31:0] p;
    p = 32'(a) * 32'(g);
    return p >>> sh;
  endfunction

  function automatic logic signed [31:0] sq(input logic signed [31:0] a);
    logic signed [31:0] p;
    p = a * a;
    return p >>> pdc_pkg::SH_SQ;
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sd32767) begin
      return 16'h7fff;
    end else if (v < -32'sd32768) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction

  function automatic logic signed [13:0] sat14(input logic signed [31:0] v);
    if (v > 32'sd8191) begin
      return 14'h1fff;
    end else if (v < -32'sd8192) begin
      return 14'h2000;
    end
    return v[13:0];
  endfunction

  // Tap k of a history: k = 0 is the value just computed, k = n is n cycles old.
  // The tap is five bits wide because delay three plus seven reaches sixteen, the oldest entry.
  function automatic logic [15:0] tap16(input logic [15:0][15:0] h, input logic [15:0] cur,
                                        input logic [4:0] k);
    if (k == 5'h00) begin
      return cur;
    end
    return h[k - 5'h01];
  endfunction

  // ----------------------------------------------------------------
  // Serial port, link side
  // ----------------------------------------------------------------
  pdc_pkg::pdc_spi_ctl_t   sp_r;
  pdc_pkg::pdc_spi_ctl_t   sp_nxt;
  pdc_pkg::pdc_spi_shift_t sh_r;
  pdc_pkg::pdc_spi_shift_t sh_nxt;
  pdc_pkg::pdc_spi_out_t   so_r;
  pdc_pkg::pdc_spi_out_t   so_nxt;
  pdc_pkg::pdc_core_t      s_r;
  pdc_pkg::pdc_core_t      s_nxt;

  always_comb begin
    sp_nxt = sp_r;
    sh_nxt = sh_r;
    if (sp_r.cnt < pdc_pkg::BIT_FRAME_END) begin
      sp_nxt.cnt = sp_r.cnt + 5'h01;
      if (sp_r.cnt == 5'h00) begin
        sp_nxt.rw = spi_sdi;
      end else if (sp_r.cnt <= pdc_pkg::BIT_ADDR_LAST) begin
        sh_nxt.addr = {sh_r.addr[10:0], spi_sdi};
      end else if (sp_r.cnt >= pdc_pkg::BIT_DATA_FST) begin
        sh_nxt.data = {sh_r.data[14:0], spi_sdi};
      end
      // The idle bit at count 13 is not decoded.
      if (sp_r.cnt == pdc_pkg::BIT_ADDR_LAST) begin
        sp_nxt.phase  = pdc_pkg::PDC_SP_DATA;
        sp_nxt.rd_req = sp_r.rw;
      end
      if (sp_r.cnt == pdc_pkg::BIT_DATA_LAST) begin
        sp_nxt.phase   = pdc_pkg::PDC_SP_DONE;
        sp_nxt.wr_done = ~sp_r.rw;
      end
    end
  end

  // A high select clears the frame, so each command starts from bit zero.
  always_ff @(posedge spi_sclk or posedge spi_ss_n) begin
    if (spi_ss_n) begin
      sp_r <= pdc_pkg::SPI_CTL_RST;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // Address and data stay put after the frame so the core can pick them up late.
  always_ff @(posedge spi_sclk) begin
    sh_r <= sh_nxt;
  end

  always_comb begin
    so_nxt = '0;
    if (sp_r.rw && sp_r.cnt >= pdc_pkg::BIT_DATA_FST && sp_r.cnt <= pdc_pkg::BIT_DATA_LAST) begin
      so_nxt.oe      = 1'b1;
      so_nxt.bit_out = s_r.rd_data[4'(pdc_pkg::BIT_DATA_LAST - sp_r.cnt)];
    end
  end

  // Output changes on the falling edge, half a bit ahead of the master's sampling edge.
  always_ff @(negedge spi_sclk or posedge spi_ss_n) begin
    if (spi_ss_n) begin
      so_r <= '0;
    end else begin
      so_r <= so_nxt;
    end
  end

  assign spi_sdo    = so_r.bit_out;
  assign spi_sdo_oe = so_r.oe;

  // ----------------------------------------------------------------
  // Core: register file and datapath
  // ----------------------------------------------------------------
  logic                     wr_edge;
  logic                     rd_edge;
  logic [15:0]              rd_word;
  logic signed [31:0]       a_lane;
  logic signed [31:0]       b_lane;
  logic signed [13:0]       x0;
  logic signed [13:0]       x1;
  logic signed [13:0]       xd1;
  logic signed [13:0]       xd2;
  logic signed [13:0]       zsel;
  logic signed [15:0]       step;
  logic signed [15:0]       step_sel;
  logic signed [31:0]       il_c;
  logic signed [31:0]       pa_c;
  logic signed [31:0]       sp_c;
  logic signed [31:0]       w;
  logic signed [13:0]       pre;
  logic signed [31:0]       hil;
  logic                     neg;
  logic [3:0]               d3;
  logic signed [15:0]       main_t;
  logic signed [15:0]       il_t;
  logic signed [15:0]       pa_t;
  logic signed [15:0]       sp_t;

  always_comb begin
    s_nxt   = s_r;
    rd_word = 16'h0000;
    s_nxt.wr_sync = {s_r.wr_sync[1:0], sp_r.wr_done};
    s_nxt.rd_sync = {s_r.rd_sync[1:0], sp_r.rd_req};
    wr_edge = s_r.wr_sync[1] & ~s_r.wr_sync[2];
    rd_edge = s_r.rd_sync[1] & ~s_r.rd_sync[2];

    // Register writes.
    if (wr_edge) begin
      if (sh_r.addr == pdc_pkg::ADDR_CONFIG) begin
        s_nxt.cfg = sh_r.data & pdc_pkg::CONFIG_MASK;
      end else if (sh_r.addr == pdc_pkg::ADDR_DELAY1) begin
        s_nxt.d1 = sh_r.data[3:0];
      end else if (sh_r.addr == pdc_pkg::ADDR_DELAY2) begin
        s_nxt.d2 = sh_r.data[3:0];
      end else if (sh_r.addr == pdc_pkg::ADDR_DELAY3) begin
        s_nxt.d3 = (sh_r.data > 16'(pdc_pkg::DELAY3_MAX)) ? pdc_pkg::DELAY3_MAX
                                                           : sh_r.data[3:0];
      end
      for (int i = 0; i < pdc_pkg::NUM_GAINS; i++) begin
        if (sh_r.addr == pdc_pkg::ADDR_GAIN_BASE + 12'(i)) begin
          // Gains nine and ten keep only eight bits of resolution.
          s_nxt.gain[i] = (i >= pdc_pkg::NARROW_GAIN_FIRST)
                        ? 12'(sh_r.data & pdc_pkg::NARROW_GAIN_MASK)
                        : 12'(sh_r.data & pdc_pkg::WIDE_GAIN_MASK);
        end
      end
    end

    // Register reads, captured once per read frame.
    if (sh_r.addr == pdc_pkg::ADDR_CONFIG) begin
      rd_word = s_r.cfg;
    end else if (sh_r.addr == pdc_pkg::ADDR_DELAY1) begin
      rd_word = 16'(s_r.d1);
    end else if (sh_r.addr == pdc_pkg::ADDR_DELAY2) begin
      rd_word = 16'(s_r.d2);
    end else if (sh_r.addr == pdc_pkg::ADDR_DELAY3) begin
      rd_word = 16'(s_r.d3);
    end else if (sh_r.addr == pdc_pkg::ADDR_STATUS) begin
      rd_word = 16'($signed(s_r.out));
    end
    for (int i = 0; i < pdc_pkg::NUM_GAINS; i++) begin
      if (sh_r.addr == pdc_pkg::ADDR_GAIN_BASE + 12'(i)) begin
        rd_word = 16'(s_r.gain[i]);
      end
    end
    if (rd_edge) begin
      s_nxt.rd_data = rd_word;
    end

    // Input: drop the LSB of each lane and blank disabled lanes.
    a_lane = s_r.cfg[pdc_pkg::CFG_AC_OFF] ? 32'sd0
           : 32'($signed(samples_in.ac[14:1]));
    b_lane = s_r.cfg[pdc_pkg::CFG_BD_OFF] ? 32'sd0
           : 32'($signed(samples_in.bd[14:1]));
    x0 = sat14(a_lane + b_lane);
    x1 = $signed(s_r.xh[0]);
    s_nxt.xh    = {s_r.xh[14:0], x0};
    s_nxt.phase = ~s_r.phase;
    s_nxt.grp   = s_r.grp + 3'h1;

    // Interleaving compensation: zero-order hold on the chosen parity.
    zsel = (s_r.phase == s_r.cfg[pdc_pkg::CFG_HOLD_PAR]) ? x0 : $signed(s_r.zoh);
    s_nxt.zoh = zsel;
    step     = sat16(32'(x0) - 32'(x1));
    step_sel = s_r.phase ? step : 16'sh0000;
    s_nxt.step_prev = step_sel;
    il_c = (s_r.phase ? mulsh(16'(zsel), $signed(s_r.gain[0]), pdc_pkg::SH_G12)
                      : 32'sd0)
         + mulsh(sat16((32'(step_sel) + 32'($signed(s_r.step_prev))) >>> 1),
                 $signed(s_r.gain[1]), pdc_pkg::SH_G12);
    s_nxt.ilh = {s_r.ilh[14:0], sat16(il_c)};

    // PA correction: squares, a cube, a fourth power and a slew term with memory taps.
    xd1  = $signed(s_r.xh[s_r.d1]);
    xd2  = $signed(s_r.xh[s_r.d2]);
    pa_c = mulsh(sat16(sq(sq(32'(x0)) <<< 0) >>> 0), $signed(s_r.gain[2]), pdc_pkg::SH_G34)
         + mulsh(sat16((sq(32'(xd1)) * 32'(xd1)) >>> pdc_pkg::SH_SQ),
                 $signed(s_r.gain[3]), pdc_pkg::SH_G34)
         + mulsh(sat16(sq(32'(x0))), $signed(s_r.gain[4]), pdc_pkg::SH_G58)
         + mulsh(sat16(sq(32'(xd1))), $signed(s_r.gain[5]), pdc_pkg::SH_G58)
         + mulsh(sat16(sq(32'(step))), $signed(s_r.gain[6]), pdc_pkg::SH_G58)
         + mulsh(sat16(sq(32'(xd2))), $signed(s_r.gain[7]), pdc_pkg::SH_G58);
    s_nxt.pah = {s_r.pah[14:0], sat16(pa_c)};

    // Half-rate spur correction.
    pre = s_r.cfg[pdc_pkg::CFG_PREFILT] ? x0
        : sat14((32'(x0) + 32'(x1)) >>> 1);
    s_nxt.ph = {s_r.ph[1:0], pre};
    hil = (32'(pre) - 32'($signed(s_r.ph[1]))) >>> 1;
    w   = mulsh(sat16(hil), 12'($signed(s_r.gain[9][7:0])), pdc_pkg::SH_G910)
        + mulsh(16'($signed(s_r.ph[0])), 12'($signed(s_r.gain[8][7:0])),
                pdc_pkg::SH_G910);
    neg  = s_r.cfg[pdc_pkg::CFG_MOD_START] ^ s_r.grp[0];
    sp_c = (neg ^ s_r.cfg[pdc_pkg::CFG_SPUR_SIGN]) ? -sq(w) : sq(w);
    s_nxt.sph = {s_r.sph[14:0], sat16(sp_c)};

    // Path alignment and output sum.
    d3     = s_r.d3;
    main_t = 16'($signed(s_r.xh[d3 + pdc_pkg::PA_EXTRA - 4'h1]));
    il_t   = $signed(tap16(s_r.ilh, sat16(il_c), 5'(d3) + 5'(pdc_pkg::IL_EXTRA)));
    pa_t   = $signed(tap16(s_r.pah, sat16(pa_c), 5'(d3) + 5'(pdc_pkg::PA_EXTRA)));
    sp_t   = $signed(tap16(s_r.sph, sat16(sp_c), 5'(d3)));
    if (s_r.cfg[pdc_pkg::CFG_BYPASS]) begin
      // Corrections are dropped and the latency shrinks by delay three.
      s_nxt.out = s_r.xh[pdc_pkg::PA_EXTRA - 4'h1];
    end else begin
      s_nxt.out = sat14(32'(main_t) + 32'(il_t) + 32'(pa_t) + 32'(sp_t));
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_r <= pdc_pkg::CORE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sample_out = s_r.out;

endmodule

`default_nettype wire

// file: rtl/pdc_pkg.sv
// Purpose: Shared constants and carrier types for the predistortion stage and its serial port.
// Assumes: One combined sample per DSP clock; serial frames of 30 bits, most significant first.
// Notes:   Every address, field position, reset value and scaling shift lives here.
package pdc_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int SAMPLE_IN_W = 15;
  localparam int SAMPLE_W    = 14;
  localparam int CORR_W      = 16;
  localparam int GAIN_W      = 12;
  localparam int NUM_GAINS   = 10;
  localparam int DELAY_W     = 4;
  localparam int HIST_DEPTH  = 16;
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 16;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CONFIG    = 12'h081;
  localparam logic [11:0] ADDR_GAIN_BASE = 12'h090;
  localparam logic [11:0] ADDR_DELAY1    = 12'h0a0;
  localparam logic [11:0] ADDR_DELAY2    = 12'h0a1;
  localparam logic [11:0] ADDR_DELAY3    = 12'h0a2;
  localparam logic [11:0] ADDR_STATUS    = 12'h0a8;

  localparam int CFG_SPUR_SIGN  = 0;
  localparam int CFG_PREFILT    = 1;
  localparam int CFG_AC_OFF     = 2;
  localparam int CFG_BD_OFF     = 3;
  localparam int CFG_HOLD_PAR   = 4;
  localparam int CFG_BYPASS     = 5;
  localparam int CFG_MOD_START  = 6;
  localparam logic [15:0] CONFIG_RST  = 16'h0000;
  localparam logic [15:0] CONFIG_MASK = 16'h007f;
  localparam int NARROW_GAIN_FIRST = 8;
  localparam logic [15:0] NARROW_GAIN_MASK = 16'h00ff;
  localparam logic [15:0] WIDE_GAIN_MASK   = 16'h0fff;

  // ----------------------------------------------------------------
  // Delays and fixed-point scaling
  // ----------------------------------------------------------------
  localparam logic [3:0] DELAY1_RST = 4'h1;
  localparam logic [3:0] DELAY2_RST = 4'hc;
  localparam logic [3:0] DELAY3_RST = 4'h6;
  localparam logic [3:0] DELAY3_MAX = 4'h9;
  localparam logic [3:0] IL_EXTRA   = 4'h6;
  localparam logic [3:0] PA_EXTRA   = 4'h7;
  localparam int SH_G12  = 14;
  localparam int SH_G34  = 20;
  localparam int SH_G58  = 16;
  localparam int SH_G910 = 12;
  localparam int SH_SQ   = 13;

  // ----------------------------------------------------------------
  // Serial frame
  // ----------------------------------------------------------------
  localparam logic [4:0] BIT_ADDR_LAST = 5'h0c;
  localparam logic [4:0] BIT_DATA_FST  = 5'h0e;
  localparam logic [4:0] BIT_DATA_LAST = 5'h1d;
  localparam logic [4:0] BIT_FRAME_END = 5'h1e;

  typedef enum logic [1:0] {
    PDC_SP_CMD  = 2'b00,
    PDC_SP_DATA = 2'b01,
    PDC_SP_DONE = 2'b10
  } pdc_spi_phase_t;

  typedef struct packed {
    logic [SAMPLE_IN_W-1:0] ac;
    logic [SAMPLE_IN_W-1:0] bd;
  } pdc_samples_t;

  typedef struct packed {
    logic [4:0]     cnt;
    pdc_spi_phase_t phase;
    logic           rw;
    logic           rd_req;
    logic           wr_done;
  } pdc_spi_ctl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pdc_spi_shift_t;

  typedef struct packed {
    logic oe;
    logic bit_out;
  } pdc_spi_out_t;

  typedef struct packed {
    logic [15:0]                         cfg;
    logic [NUM_GAINS-1:0][GAIN_W-1:0]    gain;
    logic [DELAY_W-1:0]                  d1;
    logic [DELAY_W-1:0]                  d2;
    logic [DELAY_W-1:0]                  d3;
    logic [2:0]                          wr_sync;
    logic [2:0]                          rd_sync;
    logic [DATA_W-1:0]                   rd_data;
    logic                                phase;
    logic [2:0]                          grp;
    logic [SAMPLE_W-1:0]                 zoh;
    logic [CORR_W-1:0]                   step_prev;
    logic [2:0][SAMPLE_W-1:0]            ph;
    logic [HIST_DEPTH-1:0][SAMPLE_W-1:0] xh;
    logic [HIST_DEPTH-1:0][CORR_W-1:0]   ilh;
    logic [HIST_DEPTH-1:0][CORR_W-1:0]   pah;
    logic [HIST_DEPTH-1:0][CORR_W-1:0]   sph;
    logic [SAMPLE_W-1:0]                 out;
  } pdc_core_t;

  localparam pdc_spi_ctl_t SPI_CTL_RST = '{cnt: 5'h00, phase: PDC_SP_CMD, default: '0};
  localparam pdc_core_t CORE_RST = '{cfg: CONFIG_RST, d1: DELAY1_RST, d2: DELAY2_RST,
                                     d3: DELAY3_RST, default: '0};

endpackage

// file: test/pdc_core_asserts.sv
// Purpose: Port checks of the predistortion stage.
// Assumes: 30-bit frames; gains stay zero until a write frame.
// Notes:   Frame position is rebuilt from the serial pins.
`timescale 1ns/1ps
`default_nettype none
module pdc_core_asserts (
  input wire logic                  clock,      // DSP clock
  input wire logic                  reset,      // reset
  input wire pdc_pkg::pdc_samples_t samples_in, // lanes
  input wire logic [13:0]           sample_out, // output
  input wire logic                  spi_sclk,   // serial clock
  input wire logic                  spi_ss_n,   // select
  input wire logic                  spi_sdi,    // data in
  input wire logic                  spi_sdo,    // data out
  input wire logic                  spi_sdo_oe  // out enable
);
  // ----
  // Helpers
  // ----
  logic [4:0] bits_r;
  logic       rd_r;
  logic       wrote_r;
  logic [4:0] age_r;
  always_ff @(posedge spi_sclk or posedge spi_ss_n) begin
    if (spi_ss_n) begin
      bits_r <= 5'h00;
      rd_r   <= 1'b0;
    end else begin
      bits_r <= (bits_r == 5'h1f) ? bits_r : bits_r + 5'h01;
      rd_r   <= (bits_r == 5'h00) ? spi_sdi : rd_r;
    end
  end
  // A write may change the gains, so the pass-through check stops there.
  always_ff @(posedge clock) begin
    if (reset) begin
      wrote_r <= 1'b0;
      age_r   <= 5'h00;
    end else begin
      wrote_r <= wrote_r || ((bits_r == 5'h1e) && !rd_r);
      age_r   <= (age_r == 5'h1f) ? age_r : age_r + 5'h01;
    end
  end
  function automatic logic [13:0] lane_sum(input pdc_pkg::pdc_samples_t s);
    logic [14:0] t;
    t = {s.ac[14], s.ac[14:1]} + {s.bd[14], s.bd[14:1]};
    return (t[14] != t[13]) ? (t[14] ? 14'h2000 : 14'h1fff) : t[13:0];
  endfunction
  sequence s_read_open;
    rd_r && (bits_r == 5'h0e);
  endsequence
  sequence s_frame_tail;
    (bits_r == 5'h1e) || spi_ss_n;
  endsequence
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_oe_read_start: assert property ($rose(spi_sdo_oe) |-> s_read_open)
    else $error("enable rose outside read data");
  a_oe_frame_tail: assert property ($fell(spi_sdo_oe) |-> s_frame_tail)
    else $error("enable fell early");
  a_oe_write_off: assert property ((!spi_ss_n && !rd_r && bits_r != 5'h00) |-> !spi_sdo_oe)
    else $error("output driven in a write");
  a_oe_deselect: assert property (spi_ss_n |-> !spi_sdo_oe)
    else $error("output driven while deselected");
  a_oe_data_window: assert property (spi_sdo_oe |-> rd_r && bits_r >= 5'h0e && bits_r <= 5'h1e)
    else $error("output outside data field");
  a_sdo_steady_high: assert property (spi_sclk && $past(spi_sclk) |-> $stable(spi_sdo) && $stable(spi_sdo_oe))
    else $error("output moved while clock high");
  a_reset_out_zero: assert property (disable iff (1'b0) $past(reset) || $past(reset, 2) |-> sample_out == 14'h0000)
    else $error("output not zero after reset");
  a_default_latency: assert property ((!wrote_r && age_r == 5'h1f) |-> sample_out == lane_sum($past(samples_in, 14)))
    else $error("default path mismatch");
endmodule
bind pdc_core pdc_core_asserts i_pdc_core_asserts (.clock(clock), .reset(reset),
  .samples_in(samples_in), .sample_out(sample_out), .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n),
  .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));
`default_nettype wire

// file: test/pdc_spi_host.sv
// Purpose: Serial master model driving 30-bit frames.
// Assumes: Clock idles low; bits change low, sampled rising.
// Notes:   Clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module pdc_spi_host (
  output logic     spi_sclk,   // serial clock
  output logic     spi_ss_n,   // select
  output logic     spi_sdi,    // data to device
  input wire logic spi_sdo,    // data from device
  input wire logic spi_sdo_oe  // device drives
);
  // ----
  // Frame driver
  // ----
  localparam realtime HALF = 16.0;
  logic last_r;
  initial begin
    spi_sclk = 1'b0;
    spi_ss_n = 1'b0;
    spi_sdi  = 1'b0;
    last_r   = 1'b0;
    // A rising select during reset gives the device's frame logic a defined start.
    #1;
    spi_ss_n = 1'b1;
  end
  task automatic frame(input logic rw, input logic [11:0] addr, input logic [15:0] wd,
                       output logic [15:0] rdata);
    logic [29:0] word;
    word  = {rw, addr, ~rw, wd};
    rdata = 16'h0000;
    #1.7;
    spi_ss_n = 1'b0;
    for (int k = 29; k >= 0; k--) begin
      spi_sdi = word[k];
      #HALF;
      spi_sclk = 1'b1;
      // A released line is read as the inverse of the last bit.
      last_r = spi_sdo_oe ? spi_sdo : ~last_r;
      if (k < 16) rdata[k] = last_r;
      #HALF;
      spi_sclk = 1'b0;
    end
    #HALF;
    spi_ss_n = 1'b1;
    spi_sdi  = ~spi_sdi;
    #(2 * HALF);
  endtask
endmodule
`default_nettype wire

// file: test/tb_pdc_core.sv
// Purpose: Self-checking bench of the predistortion stage.
// Assumes: Frames come from the serial master model.
// Notes:   Stream checks use zero gains or bypass only.
`timescale 1ns/1ps
`default_nettype none
module tb_pdc_core;
  logic                  clock;
  logic                  reset;
  logic                  spi_sclk;
  logic                  spi_ss_n;
  logic                  spi_sdi;
  logic                  spi_sdo;
  logic                  spi_sdo_oe;
  pdc_pkg::pdc_samples_t samples_in;
  logic [13:0]           sample_out;
  logic [15:0]           rd;
  int                    n_errors;
  int                    samples_checked;
  int                    seed;
  pdc_core i_pdc_core (.clock(clock), .reset(reset), .samples_in(samples_in),
    .sample_out(sample_out), .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));
  pdc_spi_host i_pdc_spi_host (.spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));
  initial clock = 1'b0;
  always #2 clock = ~clock;
  // ----
  // Helpers
  // ----
  function automatic logic [13:0] lane_sum(input pdc_pkg::pdc_samples_t s, input logic a_off,
                                           input logic b_off);
    logic [14:0] t;
    t = (a_off ? 15'h0000 : {s.ac[14], s.ac[14:1]}) + (b_off ? 15'h0000 : {s.bd[14], s.bd[14:1]});
    return (t[14] != t[13]) ? (t[14] ? 14'h2000 : 14'h1fff) : t[13:0];
  endfunction
  task automatic stop_test();
    $display("checked=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_smp(input logic [13:0] got, input logic [13:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [11:0] a, input logic [15:0] d);
    logic [15:0] unused;
    i_pdc_spi_host.frame(1'b0, a, d, unused);
  endtask
  task automatic reg_chk(input logic [11:0] a, input logic [15:0] exp);
    i_pdc_spi_host.frame(1'b1, a, 16'($random(seed)), rd);
    cmp_reg(rd, exp);
  endtask
  task automatic run_stream(input int lat, input logic a_off, input logic b_off);
    pdc_pkg::pdc_samples_t hist[$];
    for (int j = 0; j < 64; j++) begin
      @(negedge clock);
      if (j > lat + 4) cmp_smp(sample_out, lane_sum(hist[j - lat], a_off, b_off));
      samples_in.ac = 15'($random(seed));
      samples_in.bd = 15'($random(seed));
      if (j % 16 == 5) samples_in = {15'h3fff, 15'h3fff};
      if (j % 16 == 11) samples_in = {15'h4000, 15'h4001};
      hist.push_back(samples_in);
    end
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial begin
    seed = 23379;
    n_errors = 0;
    samples_checked = 0;
    reset = 1'b1;
    samples_in = '0;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    repeat (2) @(negedge clock);
    reg_chk(pdc_pkg::ADDR_CONFIG, pdc_pkg::CONFIG_RST);
    for (int g = 0; g < 10; g++) reg_chk(pdc_pkg::ADDR_GAIN_BASE + 12'(g), 16'h0000);
    reg_chk(pdc_pkg::ADDR_DELAY1, 16'h0001);
    reg_chk(pdc_pkg::ADDR_DELAY2, 16'h000c);
    reg_chk(pdc_pkg::ADDR_DELAY3, 16'h0006);
    reg_chk(12'h0ff, 16'h0000);
    run_stream(14, 1'b0, 1'b0);
    reg_wr(pdc_pkg::ADDR_DELAY3, 16'h000a + 16'($unsigned($random(seed)) % 6));
    reg_chk(pdc_pkg::ADDR_DELAY3, 16'h0009);
    run_stream(17, 1'b0, 1'b0);
    reg_wr(pdc_pkg::ADDR_DELAY3, 16'h0000);
    reg_chk(pdc_pkg::ADDR_DELAY3, 16'h0000);
    run_stream(8, 1'b0, 1'b0);
    reg_wr(pdc_pkg::ADDR_DELAY1, 16'h000f);
    reg_chk(pdc_pkg::ADDR_DELAY1, 16'h000f);
    reg_wr(pdc_pkg::ADDR_DELAY2, 16'h0000);
    reg_chk(pdc_pkg::ADDR_DELAY2, 16'h0000);
    reg_wr(pdc_pkg::ADDR_GAIN_BASE, 16'h0fff);
    reg_chk(pdc_pkg::ADDR_GAIN_BASE, 16'h0fff);
    reg_wr(pdc_pkg::ADDR_GAIN_BASE + 12'h008, 16'h0fff);
    reg_chk(pdc_pkg::ADDR_GAIN_BASE + 12'h008, 16'h00ff);
    reg_wr(pdc_pkg::ADDR_DELAY3, 16'h0005);
    reg_wr(pdc_pkg::ADDR_CONFIG, 16'h0020);
    run_stream(8, 1'b0, 1'b0);
    reg_wr(pdc_pkg::ADDR_CONFIG, 16'h0024);
    run_stream(8, 1'b1, 1'b0);
    reg_wr(pdc_pkg::ADDR_CONFIG, 16'h0028);
    run_stream(8, 1'b0, 1'b1);
    reg_wr(pdc_pkg::ADDR_CONFIG, 16'hffff);
    reg_chk(pdc_pkg::ADDR_CONFIG, pdc_pkg::CONFIG_MASK);
    stop_test();
  end
endmodule
`default_nettype wire
